// ===== tmh_map.svh
`ifndef TMH_MAP_SVH
`define TMH_MAP_SVH
// ==========================================================================
// Register addresses on the CPU data bus
`define TMH_ADDR_T0_CMP0 16'hFF18
`define TMH_ADDR_T0_CMP1 16'hFF19
`define TMH_ADDR_T1_CMP0 16'hFF1A
`define TMH_ADDR_T1_CMP1 16'hFF1B
`define TMH_ADDR_T0_MODE 16'hFF69
`define TMH_RST_VAL      8'h00
`define TMH_ZERO         8'h00
`define TMH_ONE          8'h01
// ==========================================================================
// Mode register field positions
`define TMH_RUN_BIT 7
`define TMH_CKS_HI  6
`define TMH_CKS_LO  4
`define TMH_MD_HI   3
`define TMH_MD_LO   2
`define TMH_LEV_BIT 1
`define TMH_OEN_BIT 0
// ==========================================================================
// Clock select and mode codes
`define TMH_CKS_DIV1  3'h0
`define TMH_CKS_DIV2  3'h1
`define TMH_CKS_DIV4  3'h2
`define TMH_CKS_DIV64 3'h3
`define TMH_CKS_DIV1K 3'h4
`define TMH_CKS_NBR   3'h5
`define TMH_MD_INTERVAL 2'h0
`define TMH_MD_CARRIER  2'h1
`define TMH_MD_PWM      2'h2
// Prescaler taps: /2 = bit 0, /4 = bits 1:0, /64 = bits 5:0, /1024 = bits 9:0.
`define TMH_DIV_W    10
`define TMH_TAP2_HI  0
`define TMH_TAP4_HI  1
`define TMH_TAP64_HI 5
`endif

// ===== tmh_pkg.sv
`default_nettype none
// ==========================================================================
// Shared types of the compare timer
package tmh_pkg;
    typedef logic [7:0]  tmh_byte_t;
    typedef logic [15:0] tmh_addr_t;
endpackage
`default_nettype wire

// ===== tmh_timer.sv
`include "tmh_map.svh"
`default_nettype none
// Notes on behaviour
// - Primary compare equal to counter raises interrupt and toggles timer output.
// - Primary compare works in interval, PWM and carrier modes; in carrier mode it does not clear counter.
// - Secondary compare matches count in all modes except interval.
// - PWM mode: secondary match toggles output, raises no interrupt.
// - Carrier mode: secondary match raises interrupt and clears counter together.
// - Secondary write while running waits in holding latch until next old match.
// - Secondary write coinciding with its match leaves active value unchanged.
// - Run bit 7: zero halts and zeroes counter, one counts selected clock.
// - Clock select: full, /2, /4, /64, /1024, neighbour output; others prohibited.
// - Mode field: 00 interval, 01 carrier, 10 PWM; 11 prohibited.
// - Bit 1 sets default output level, bit 0 enables timer output.
// - Pin level depends on port direction and latch bits plus timer output.
// - Mode register takes bit and byte writes; compares take byte accesses.
// - Interval mode: primary match raises interrupt and clears counter to zero.
// - Interval mode: secondary compare value never affects timer output.
module tmh_timer (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_b,
    // CPU data bus
    input  wire tmh_pkg::tmh_addr_t bus_addr,
    input  wire logic               bus_wr,
    input  wire logic               bus_bit,
    input  wire logic [2:0]         bus_bit_num,
    input  wire tmh_pkg::tmh_byte_t bus_wdata,
    input  wire logic               bus_rd,
    output logic [7:0]              bus_rdata,
    // Neighbour event counter output, used as count clock
    input  wire logic               neighbour_event_counter,
    // Port control bits sharing the pin
    input  wire logic               port_direction_bit,
    input  wire logic               port_latch_bit,
    // Timer results
    output logic                    timer_interrupt_request,
    output logic                    timer_output,
    output logic                    pin_o,
    output logic                    pin_oe
);
    // ======================================================================
    // Reset release
    logic [1:0] rst_sync_r;
    wire        rst_n_i = rst_sync_r[1];

    // The release is synchronised; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) rst_sync_r <= 2'h0;
        else        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    // ======================================================================
    // Registers
    tmh_pkg::tmh_byte_t mode_r, cmp0_r, cmp1_hold_r, cmp1_act_r;
    tmh_pkg::tmh_byte_t t1_cmp0_r, t1_cmp1_r, cnt_r, rdata_r;
    logic               pend_r, tof_r, irq_r, nbr_prev_r;
    logic [`TMH_DIV_W-1:0] div_r;

    // Address decode; compares ignore bit accesses.
    wire sel_c0   = bus_addr == `TMH_ADDR_T0_CMP0;
    wire sel_c1   = bus_addr == `TMH_ADDR_T0_CMP1;
    wire sel_t10  = bus_addr == `TMH_ADDR_T1_CMP0;
    wire sel_t11  = bus_addr == `TMH_ADDR_T1_CMP1;
    wire sel_md   = bus_addr == `TMH_ADDR_T0_MODE;
    wire wr_byte  = bus_wr && !bus_bit;
    wire cmp0_wr  = wr_byte && sel_c0;
    wire cmp1_wr  = wr_byte && sel_c1;
    wire mode_wr  = bus_wr && sel_md;
    wire [7:0] bit_mask = `TMH_ONE << bus_bit_num;
    wire [7:0] mode_wval = bus_bit ?
        (bus_wdata[0] ? (mode_r | bit_mask) : (mode_r & ~bit_mask)) :
        bus_wdata;

    // Mode register fields.
    wire       run      = mode_r[`TMH_RUN_BIT];
    wire [2:0] cks      = mode_r[`TMH_CKS_HI:`TMH_CKS_LO];
    wire [1:0] md       = mode_r[`TMH_MD_HI:`TMH_MD_LO];
    wire       lev      = mode_r[`TMH_LEV_BIT];
    wire       oen      = mode_r[`TMH_OEN_BIT];
    wire       is_int   = md == `TMH_MD_INTERVAL;
    wire       is_pwm   = md == `TMH_MD_PWM;
    wire       is_car   = md == `TMH_MD_CARRIER;

    // ======================================================================
    // Count clock selection
    // Neighbour output is taken as synchronous; its rising edge is one count.
    wire nbr_edge = neighbour_event_counter && !nbr_prev_r;
    // Prohibited codes give no count clock, so the timer simply stays still.
    wire tick =
        (cks == `TMH_CKS_DIV1)  ? 1'b1 :
        (cks == `TMH_CKS_DIV2)  ? div_r[`TMH_TAP2_HI] :
        (cks == `TMH_CKS_DIV4)  ? &div_r[`TMH_TAP4_HI:0] :
        (cks == `TMH_CKS_DIV64) ? &div_r[`TMH_TAP64_HI:0] :
        (cks == `TMH_CKS_DIV1K) ? &div_r :
        (cks == `TMH_CKS_NBR)   ? nbr_edge : 1'b0;

    // ======================================================================
    // Match detection, evaluated on the count clock only
    wire cnt_tick = run && tick;
    wire m0   = cnt_tick && (cnt_r == cmp0_r);
    wire m1   = cnt_tick && !is_int && (cnt_r == cmp1_act_r);
    wire clr  = (m0 && !is_car) || (m1 && is_car);
    wire tog  = m0 || (m1 && is_pwm);
    wire irq  = m0 || (m1 && is_car);
    wire load = m1 && pend_r && !cmp1_wr;

    // ======================================================================
    // Prescaler and neighbour edge history
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r      <= '0;
            nbr_prev_r <= 1'b0;
        end else begin
            div_r      <= div_r + 1'b1;
            nbr_prev_r <= neighbour_event_counter;
        end
    end

    // Software registers; reset leaves the timer stopped and silent.
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r    <= `TMH_RST_VAL;
            cmp0_r    <= `TMH_RST_VAL;
            t1_cmp0_r <= `TMH_RST_VAL;
            t1_cmp1_r <= `TMH_RST_VAL;
        end else begin
            if (mode_wr) mode_r <= mode_wval;
            if (cmp0_wr) cmp0_r <= bus_wdata;
            if (wr_byte && sel_t10) t1_cmp0_r <= bus_wdata;
            if (wr_byte && sel_t11) t1_cmp1_r <= bus_wdata;
        end
    end

    // Secondary compare: the holding latch is what software reads back, so
    // a read between write and transfer shows the new, not yet active value.
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp1_hold_r <= `TMH_RST_VAL;
            cmp1_act_r  <= `TMH_RST_VAL;
            pend_r      <= 1'b0;
        end else begin
            if (cmp1_wr) cmp1_hold_r <= bus_wdata;
            if (cmp1_wr && !run) begin
                cmp1_act_r <= bus_wdata;
                pend_r     <= 1'b0;
            end else if (cmp1_wr) begin
                pend_r     <= 1'b1;
            end else if (load) begin
                cmp1_act_r <= cmp1_hold_r;
                pend_r     <= 1'b0;
            end
        end
    end

    // Counter, output flip-flop and interrupt pulse.
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= `TMH_ZERO;
            tof_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq;
            if (!run) begin
                cnt_r <= `TMH_ZERO;
                tof_r <= lev;
            end else begin
                if (clr)           cnt_r <= `TMH_ZERO;
                else if (cnt_tick) cnt_r <= cnt_r + 1'b1;
                if (tog) tof_r <= !tof_r;
            end
        end
    end

    // Read data is captured on the read strobe; unmapped addresses read zero.
    wire [7:0] rd_mux =
        sel_c0  ? cmp0_r      : sel_c1  ? cmp1_hold_r :
        sel_t10 ? t1_cmp0_r   : sel_t11 ? t1_cmp1_r   :
        sel_md  ? mode_r      : `TMH_ZERO;
    always_ff @(posedge core_clk or negedge rst_n_i) begin
        if (!rst_n_i)    rdata_r <= `TMH_ZERO;
        else if (bus_rd) rdata_r <= rd_mux;
    end

    // ======================================================================
    // Outputs; a set port latch forces the pin high whatever the timer does.
    assign bus_rdata               = rdata_r;
    assign timer_interrupt_request = irq_r;
    assign timer_output            = oen && tof_r;
    assign pin_o                   = port_latch_bit || timer_output;
    assign pin_oe                  = !port_direction_bit;

    // ======================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_i);

    a_stop_holds_zero: assert property (!run |=> cnt_r == `TMH_ZERO)
        else $error("counter not held at zero while stopped");
    a_match_irq_tog: assert property (m0 |=> irq_r && (!run || tof_r != $past(tof_r)))
        else $error("primary match missed interrupt or toggle");
    a_pwm_no_irq: assert property (is_pwm && m1 && !m0 |=> !irq_r ##0 tof_r != $past(tof_r))
        else $error("pwm secondary match misbehaved");
    a_carrier_clear: assert property (is_car && m1 |=> irq_r && cnt_r == `TMH_ZERO)
        else $error("carrier secondary match did not clear");
    a_interval_ign: assert property (is_int && run && !m0 ##1 run |-> tof_r == $past(tof_r))
        else $error("interval mode output moved without primary match");
    a_reload_act: assert property (load |=> cmp1_act_r == $past(cmp1_hold_r))
        else $error("held secondary value not transferred");
    a_conflict_keep: assert property (m1 && cmp1_wr |=> cmp1_act_r == $past(cmp1_act_r))
        else $error("secondary changed on conflicting write");
    a_interval_zero: assert property (is_int && m0 |=> cnt_r == `TMH_ZERO && irq_r)
        else $error("interval match did not clear counter");
    a_count_step: assert property (cnt_tick && !clr ##1 run |-> cnt_r == $past(cnt_r) + 8'h01)
        else $error("counter did not step by one");
    a_out_gated: assert property (!oen |-> !timer_output)
        else $error("timer output active while disabled");

    c_interval_wrap: cover property (is_int && m0 ##1 cnt_r == `TMH_ZERO);
    c_pwm_both: cover property (is_pwm && m1 ##[1:600] m0);
    c_reload: cover property (cmp1_wr && run ##[1:600] load);
    c_carrier: cover property (is_car && m1);
endmodule
`default_nettype wire

// ===== tb_eight_bit_compare_timer_pair.sv
`include "tmh_map.svh"
`default_nettype none
module tb_eight_bit_compare_timer_pair;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================================
    // Stimulus and observation
    logic               core_clk  = 1'b0;
    logic               rst_b     = 1'b0;
    tmh_pkg::tmh_addr_t bus_addr  = 16'h0000;
    logic               bus_wr    = 1'b0;
    logic               bus_bit   = 1'b0;
    logic [2:0]         bus_bit_n = 3'h0;
    tmh_pkg::tmh_byte_t bus_wdata = 8'h00;
    logic               bus_rd    = 1'b0;
    logic [7:0]         bus_rdata;
    logic               dir_b     = 1'b0;
    logic               latch     = 1'b0;
    logic [1:0]         nbr_cnt   = 2'h0;
    logic               irq;
    logic               tout;
    logic               pin_o;
    logic               pin_oe;
    int                 fails     = 0;
    int                 compares  = 0;
    logic [15:0]        p;
    logic [15:0]        t;
    logic [15:0]        f;

    tmh_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_bit(bus_bit), .bus_bit_num(bus_bit_n), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .neighbour_event_counter(nbr_cnt[1]),
        .port_direction_bit(dir_b), .port_latch_bit(latch), .timer_interrupt_request(irq),
        .timer_output(tout), .pin_o(pin_o), .pin_oe(pin_oe));

    // ==========================================================================
    // Clock, and a neighbour counter output that rises once every four cycles.
    always #4 core_clk = ~core_clk;
    // Bit 1 runs at a steady half duty, as a neighbour counter set up for this must.
    always @(negedge core_clk) nbr_cnt <= nbr_cnt + 2'h1;

    // ==========================================================================
    // Shared tasks: all inputs move at the falling edge so the sampling edge is clean.
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input tmh_pkg::tmh_addr_t a, input tmh_pkg::tmh_byte_t d,
                      input logic b = 1'b0, input logic [2:0] n = 3'h0);
        @(negedge core_clk);
        bus_addr  = a;
        bus_wdata = d;
        bus_bit   = b;
        bus_bit_n = n;
        bus_wr    = 1'b1;
        @(negedge core_clk);
        bus_wr    = 1'b0;
        bus_bit   = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic rchk(input string nm, input tmh_pkg::tmh_addr_t a, input logic [7:0] e);
        @(negedge core_clk);
        bus_addr = a;
        bus_rd   = 1'b1;
        @(negedge core_clk);
        bus_rd   = 1'b0;
        chk(nm, {8'h00, bus_rdata}, {8'h00, e});
    endtask

    // Cycles between two interrupt pulses, output toggles in that span, and the
    // cycle of the first toggle, which shows where the secondary match sits.
    task automatic per;
        int   i;
        logic last;
        i = 0;
        while (irq !== 1'b1 && i < 5000) begin
            @(negedge core_clk);
            i++;
        end
        p    = 16'h0000;
        t    = 16'h0000;
        f    = 16'h0000;
        last = tout;
        do begin
            @(negedge core_clk);
            p++;
            if (tout !== last) begin
                t++;
                if (f == 16'h0000) f = p;
            end
            last = tout;
        end while (irq !== 1'b1 && p < 16'h1388);
    endtask

    // Stop first: mode bits and the primary compare may change only while stopped.
    task automatic start(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] md);
        wr(`TMH_ADDR_T0_MODE, 8'h00, 1'b1, 3'h7);
        wr(`TMH_ADDR_T0_MODE, 8'h00);
        wr(`TMH_ADDR_T0_CMP0, c0);
        wr(`TMH_ADDR_T0_CMP1, c1);
        wr(`TMH_ADDR_T0_MODE, md);
    endtask

    // ==========================================================================
    // Scenarios.
    task automatic t_reset;
        rchk("cmp0", `TMH_ADDR_T0_CMP0, 8'h00);
        rchk("cmp1", `TMH_ADDR_T0_CMP1, 8'h00);
        rchk("t1cmp0", `TMH_ADDR_T1_CMP0, 8'h00);
        rchk("t1cmp1", `TMH_ADDR_T1_CMP1, 8'h00);
        rchk("mode", `TMH_ADDR_T0_MODE, 8'h00);
        chk("tout_rst", {15'h0000, tout}, 16'h0000);
        wr(16'hFF20, 8'h5A);
        rchk("unmapped", 16'hFF20, 8'h00);
    endtask

    task automatic t_interval;
        start(8'h03, 8'h01, 8'h81);
        per();
        chk("int_period", p, 16'h0004);
        chk("int_toggles", t, 16'h0001);
        rchk("cmp0_rb", `TMH_ADDR_T0_CMP0, 8'h03);
    endtask

    task automatic t_clocks;
        logic [15:0] ex [6];
        ex = '{16'h0002, 16'h0004, 16'h0008, 16'h0080, 16'h0800, 16'h0008};
        for (int k = 0; k < 6; k++) begin
            start(8'h01, 8'h00, 8'h81 | (8'(k) << 4));
            per();
            chk("cks_period", p, ex[k]);
        end
    endtask

    // The secondary compare is rewritten on every restart, as the far side must.
    task automatic t_pwm;
        start(8'h07, 8'h02, 8'h89);
        per();
        chk("pwm_period", p, 16'h0008);
        chk("pwm_toggles", t, 16'h0002);
        chk("pwm_duty", f, 16'h0003);
        wr(`TMH_ADDR_T0_CMP1, 8'h04);
        per();
        per();
        chk("pwm_period2", p, 16'h0008);
        chk("pwm_duty2", f, 16'h0005);
        rchk("cmp1_rb", `TMH_ADDR_T0_CMP1, 8'h04);
        wr(`TMH_ADDR_T0_CMP1, 8'h01);
        per();
        per();
        chk("pwm_duty3", f, 16'h0002);
        // Issued straight after an interrupt, this write lands on the match at count 1.
        wr(`TMH_ADDR_T0_CMP1, 8'h03);
        per();
        chk("pwm_keep", f, 16'h0002);
        per();
        chk("pwm_late", f, 16'h0004);
        start(8'h09, 8'h03, 8'h85);
        per();
        chk("car_period", p, 16'h0004);
    endtask

    task automatic t_output;
        int n;
        wr(`TMH_ADDR_T0_MODE, 8'h00, 1'b1, 3'h7);
        n = 0;
        repeat (20) begin
            @(negedge core_clk);
            if (irq !== 1'b0) n++;
        end
        chk("stopped_irq", 16'(n), 16'h0000);
        // The output flip-flop takes the default level one edge after the write.
        wr(`TMH_ADDR_T0_MODE, 8'h03);
        @(negedge core_clk);
        chk("lev_hi", {15'h0000, tout}, 16'h0001);
        wr(`TMH_ADDR_T0_MODE, 8'h01);
        @(negedge core_clk);
        chk("lev_lo", {15'h0000, tout}, 16'h0000);
        wr(`TMH_ADDR_T0_MODE, 8'h01, 1'b1, 3'h1);
        rchk("bit_wr", `TMH_ADDR_T0_MODE, 8'h03);
        chk("pin_tout", {15'h0000, pin_o}, 16'h0001);
        chk("pin_oe", {15'h0000, pin_oe}, 16'h0001);
        wr(`TMH_ADDR_T0_MODE, 8'h02);
        latch = 1'b1;
        dir_b = 1'b1;
        @(negedge core_clk);
        chk("oen_off", {15'h0000, tout}, 16'h0000);
        chk("pin_latch", {15'h0000, pin_o}, 16'h0001);
        chk("pin_in", {15'h0000, pin_oe}, 16'h0000);
    endtask

    // ==========================================================================
    // Main sequence, and a watchdog well beyond the expected run length.
    initial begin
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (3) @(negedge core_clk);
        t_reset();
        t_interval();
        t_clocks();
        t_pwm();
        t_output();
        end_of_test();
    end

    initial begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
